//--- common/dfc_pkg.sv
// Purpose: Shared constants and types for the dynamic floor control register 1 block
// Assumes: Register access arrives as a simple write/read strobe pair from the serial front end
// Notes:   Offsets are the byte addresses of the device register map
`default_nettype none
package dfc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_OP_REMOTE1 = 8'h33;
    localparam logic [7:0] ADDR_OP_LOCAL   = 8'h34;
    localparam logic [7:0] ADDR_OP_REMOTE2 = 8'h35;
    localparam logic [7:0] ADDR_CTRL1      = 8'h36;
    localparam logic [7:0] ADDR_CTRL2      = 8'h37;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] OP_RESET    = 8'h64;

    // ==========================================================
    // Field positions
    localparam int BIT_CYCLE_MSB   = 0;
    localparam int BIT_CORE_LOW    = 1;
    localparam int BIT_CAP_REMOTE1 = 2;
    localparam int BIT_CAP_LOCAL   = 3;
    localparam int BIT_CAP_REMOTE2 = 4;
    localparam int CTRL2_CYC_LSB   = 0;
    localparam int CTRL2_CYC_W     = 2;

    // ==========================================================
    // Types
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dfc_bus_t;

    typedef struct packed {
        logic [7:0] remote1;
        logic [7:0] local_t;
        logic [7:0] remote2;
    } dfc_temps_t;

    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] op_remote1;
        logic [7:0] op_local;
        logic [7:0] op_remote2;
        logic [7:0] rdata;
        logic       rvalid;
    } dfc_state_t;

endpackage : dfc_pkg

`default_nettype wire

//--- rtl/dfc_reg1.sv
// Purpose: Dynamic floor control register 1 with guard and event capture logic
// Assumes: Bus strobes and sensor inputs are synchronous to clk_i
// Notes:   Locked registers silently drop writes
// Function
// - Bit 0 is the top bit of the remote-2 cycle code; control 2 holds the low two bits.
// - The three-bit cycle code sets the monitoring cycles between fan-start temperature steps.
// - With the guard set on standby, a low core voltage sets status 1 bit 1 and raises alert.
// - While the guard holds, processor-hot monitoring and dynamic floor control are off.
// - While the guard holds, shutdown is blocked.
// - Suspended functions return once core voltage is back above its low limit.
// - Remote-1 capture bit set and event pin asserted copies remote-1 temperature.
// - Remote-1 capture bit clear ignores the event pin and keeps the programmed value.
// - Local capture bit set and event pin asserted copies local temperature.
// - Local capture bit clear ignores the event pin and keeps the programmed value.
// - Remote-2 capture bit set and event pin asserted copies remote-2 temperature.
// - Remote-2 capture bit clear ignores the event pin and keeps the programmed value.
// - Once the lock bit is set, writes to these registers are rejected.
`timescale 1ns/100ps
`default_nettype none

module dfc_reg1 (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire dfc_pkg::dfc_bus_t   bus_i,
    output logic [7:0]               rdata_o,
    output logic                     rvalid_o,
    input  wire logic                lock_i,
    input  wire logic                standby_i,
    input  wire logic                core_below_i,
    input  wire logic                thermal_event_pin_n_i,
    input  wire dfc_pkg::dfc_temps_t temps_i,
    input  wire logic                processor_hot_input_i,
    input  wire logic                shutdown_req_i,
    output logic [2:0]               remote2_cycle_code_o,
    output logic                     core_low_status_o,
    output logic                     alert_req_o,
    output logic                     processor_hot_mon_o,
    output logic                     dyn_floor_allow_o,
    output logic                     shutdown_o,
    output logic [7:0]               op_remote1_o,
    output logic [7:0]               op_local_o,
    output logic [7:0]               op_remote2_o
);

    dfc_pkg::dfc_state_t st;
    dfc_pkg::dfc_state_t next_st;
    logic                guard;
    logic                event_on;
    logic                wr_ok;

    // ==========================================================
    // Guard condition
    assign guard    = st.ctrl1[dfc_pkg::BIT_CORE_LOW] & standby_i & core_below_i;
    assign event_on = ~thermal_event_pin_n_i;
    assign wr_ok    = bus_i.write & ~lock_i;

    // ==========================================================
    // Next state
    always_comb begin
        next_st        = st;
        next_st.rvalid = bus_i.read;
        if (wr_ok) begin
            case (bus_i.addr)
                dfc_pkg::ADDR_CTRL1:      next_st.ctrl1      = bus_i.wdata;
                dfc_pkg::ADDR_CTRL2:      next_st.ctrl2      = bus_i.wdata;
                dfc_pkg::ADDR_OP_REMOTE1: next_st.op_remote1 = bus_i.wdata;
                dfc_pkg::ADDR_OP_LOCAL:   next_st.op_local   = bus_i.wdata;
                dfc_pkg::ADDR_OP_REMOTE2: next_st.op_remote2 = bus_i.wdata;
                default: begin
                end
            endcase
        end
        // Capture wins over a same-cycle write
        if (event_on && st.ctrl1[dfc_pkg::BIT_CAP_REMOTE1]) begin
            next_st.op_remote1 = temps_i.remote1;
        end
        if (event_on && st.ctrl1[dfc_pkg::BIT_CAP_LOCAL]) begin
            next_st.op_local = temps_i.local_t;
        end
        if (event_on && st.ctrl1[dfc_pkg::BIT_CAP_REMOTE2]) begin
            next_st.op_remote2 = temps_i.remote2;
        end
        case (bus_i.addr)
            dfc_pkg::ADDR_CTRL1:      next_st.rdata = st.ctrl1;
            dfc_pkg::ADDR_CTRL2:      next_st.rdata = st.ctrl2;
            dfc_pkg::ADDR_OP_REMOTE1: next_st.rdata = st.op_remote1;
            dfc_pkg::ADDR_OP_LOCAL:   next_st.rdata = st.op_local;
            dfc_pkg::ADDR_OP_REMOTE2: next_st.rdata = st.op_remote2;
            default:                  next_st.rdata = '0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{ctrl1: dfc_pkg::CTRL1_RESET, ctrl2: dfc_pkg::CTRL2_RESET,
                    op_remote1: dfc_pkg::OP_RESET, op_local: dfc_pkg::OP_RESET,
                    op_remote2: dfc_pkg::OP_RESET, rdata: '0, rvalid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata_o              = st.rdata;
    assign rvalid_o             = st.rvalid;
    // Top code bit from here, low bits from control 2
    assign remote2_cycle_code_o = {
        st.ctrl1[dfc_pkg::BIT_CYCLE_MSB],
        st.ctrl2[dfc_pkg::CTRL2_CYC_LSB +: dfc_pkg::CTRL2_CYC_W]
    };
    assign core_low_status_o    = guard;
    assign alert_req_o          = guard;
    assign processor_hot_mon_o  = processor_hot_input_i & ~guard;
    assign dyn_floor_allow_o    = ~guard;
    assign shutdown_o           = shutdown_req_i & ~guard;
    assign op_remote1_o         = st.op_remote1;
    assign op_local_o           = st.op_local;
    assign op_remote2_o         = st.op_remote2;

    // ==========================================================
    // Checks: register access
    lock_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_i && bus_i.write && bus_i.addr == dfc_pkg::ADDR_CTRL1)
        |=> $stable(st.ctrl1))
        else $error("locked write changed control 1");

    lock_ctrl2_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_i && bus_i.write && bus_i.addr == dfc_pkg::ADDR_CTRL2)
        |=> $stable(st.ctrl2))
        else $error("locked write changed control 2");

    lock_op_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_i && bus_i.write && !event_on)
        |=> $stable(op_remote1_o) && $stable(op_local_o) && $stable(op_remote2_o))
        else $error("locked write changed an operating point");

    rd_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_i.read
        |=> rvalid_o)
        else $error("read not answered");

    rd_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !bus_i.read
        |=> !rvalid_o)
        else $error("read valid without a read");

    // ==========================================================
    // Checks: cycle code
    cycle_msb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_ok && bus_i.addr == dfc_pkg::ADDR_CTRL1)
        |=> remote2_cycle_code_o[dfc_pkg::CTRL2_CYC_W]
            == $past(bus_i.wdata[dfc_pkg::BIT_CYCLE_MSB]))
        else $error("cycle msb not taken");

    cycle_lsb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_ok && bus_i.addr == dfc_pkg::ADDR_CTRL2)
        |=> remote2_cycle_code_o[dfc_pkg::CTRL2_CYC_W-1:0]
            == $past(bus_i.wdata[dfc_pkg::CTRL2_CYC_LSB +: dfc_pkg::CTRL2_CYC_W]))
        else $error("cycle low bits not taken");

    // ==========================================================
    // Checks: event capture
    cap_r1_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (event_on && st.ctrl1[dfc_pkg::BIT_CAP_REMOTE1])
        |=> op_remote1_o == $past(temps_i.remote1))
        else $error("remote1 capture missed");

    keep_r1_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st.ctrl1[dfc_pkg::BIT_CAP_REMOTE1] && !wr_ok)
        |=> $stable(op_remote1_o))
        else $error("remote1 changed without capture");

    cap_loc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (event_on && st.ctrl1[dfc_pkg::BIT_CAP_LOCAL])
        |=> op_local_o == $past(temps_i.local_t))
        else $error("local capture missed");

    keep_loc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st.ctrl1[dfc_pkg::BIT_CAP_LOCAL] && !wr_ok)
        |=> $stable(op_local_o))
        else $error("local changed without capture");

    cap_r2_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (event_on && st.ctrl1[dfc_pkg::BIT_CAP_REMOTE2])
        |=> op_remote2_o == $past(temps_i.remote2))
        else $error("remote2 capture missed");

    keep_r2_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st.ctrl1[dfc_pkg::BIT_CAP_REMOTE2] && !wr_ok)
        |=> $stable(op_remote2_o))
        else $error("remote2 changed without capture");

    // ==========================================================
    // Checks: core-low guard
    guard_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.ctrl1[dfc_pkg::BIT_CORE_LOW] && standby_i && core_below_i)
        |-> core_low_status_o && alert_req_o)
        else $error("guard status not raised");

    guard_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !st.ctrl1[dfc_pkg::BIT_CORE_LOW]
        |-> !core_low_status_o && !alert_req_o)
        else $error("guard raised with guard bit clear");

    guard_standby_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !standby_i
        |-> !core_low_status_o && !alert_req_o)
        else $error("guard raised off standby");

    guard_supp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        core_low_status_o
        |-> !processor_hot_mon_o && !dyn_floor_allow_o)
        else $error("guard did not suspend");

    guard_noshut_a: assert property (@(posedge clk_i) disable iff (rst_i)
        core_low_status_o
        |-> !shutdown_o)
        else $error("shutdown during guard");

    guard_restore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !core_below_i
        |-> dyn_floor_allow_o && shutdown_o == shutdown_req_i
            && processor_hot_mon_o == processor_hot_input_i)
        else $error("functions not restored");

endmodule : dfc_reg1

`default_nettype wire

//--- bench/dfc_host.sv
// Purpose: Host model issuing register strobes to the floor control block
// Assumes: Strobes change at the falling edge, one cycle wide
// Notes:   Read answer is sampled one cycle after the request edge
`timescale 1ns/100ps
`default_nettype none
module dfc_host (
    input  wire logic               clk_i,
    output var dfc_pkg::dfc_bus_t   bus_o,
    input  wire logic               rvalid_i,
    input  wire logic [7:0]         rdata_i
);
    initial bus_o = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        bus_o = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        bus_o = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        bus_o = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        bus_o = '0;
        ok = rvalid_i;
        d = rdata_i;
    endtask : rd
endmodule : dfc_host
`default_nettype wire

//--- bench/tb_dfc_reg1.sv
// Purpose: Self-checking bench for the floor control register 1 block
// Assumes: Inputs change at the falling edge
// Notes:   Each scenario is one task
`timescale 1ns/100ps
`default_nettype none
module tb_dfc_reg1;
    logic clk_i = 0, rst_i = 1, rvalid_o, lock_i = 0, standby_i = 0, core_below_i = 0;
    logic thermal_event_pin_n_i = 1, processor_hot_input_i = 0, shutdown_req_i = 0;
    logic core_low_status_o, alert_req_o, processor_hot_mon_o, dyn_floor_allow_o, shutdown_o;
    logic [7:0] rdata_o, op_remote1_o, op_local_o, op_remote2_o, d;
    logic [2:0] remote2_cycle_code_o;
    logic ok;
    dfc_pkg::dfc_bus_t bus_i;
    dfc_pkg::dfc_temps_t temps_i = '{remote1: 8'h41, local_t: 8'h2A, remote2: 8'h55};
    int num_errors = 0, n_compared = 0;
    always #25 clk_i = ~clk_i;
    dfc_host host (.clk_i, .bus_o(bus_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o));
    dfc_reg1 DUT (.clk_i, .rst_i, .bus_i, .rdata_o, .rvalid_o, .lock_i, .standby_i,
        .core_below_i, .thermal_event_pin_n_i, .temps_i, .processor_hot_input_i,
        .shutdown_req_i, .remote2_cycle_code_o, .core_low_status_o, .alert_req_o,
        .processor_hot_mon_o, .dyn_floor_allow_o, .shutdown_o, .op_remote1_o,
        .op_local_o, .op_remote2_o);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rdchk
    task automatic event_pulse();
        @(negedge clk_i);
        thermal_event_pin_n_i = 0;
        @(negedge clk_i);
        thermal_event_pin_n_i = 1;
    endtask : event_pulse
    // ==========================================================
    // Scenarios
    task automatic t_reset_and_cycle();
        rdchk(dfc_pkg::ADDR_CTRL1, dfc_pkg::CTRL1_RESET);
        chk(op_local_o, dfc_pkg::OP_RESET);
        host.wr(dfc_pkg::ADDR_CTRL1, 8'h1D);
        host.wr(dfc_pkg::ADDR_CTRL2, 8'h02);
        chk({5'h00, remote2_cycle_code_o}, 8'h06);
        host.wr(dfc_pkg::ADDR_CTRL2, 8'h01);
        chk({5'h00, remote2_cycle_code_o}, 8'h05);
        rdchk(dfc_pkg::ADDR_CTRL1, 8'h1D);
        rdchk(dfc_pkg::ADDR_CTRL2, 8'h01);
    endtask : t_reset_and_cycle
    task automatic t_capture();
        event_pulse();
        chk(op_remote1_o, 8'h41);
        chk(op_local_o, 8'h2A);
        chk(op_remote2_o, 8'h55);
        host.wr(dfc_pkg::ADDR_CTRL1, 8'h01);
        host.wr(dfc_pkg::ADDR_OP_REMOTE1, 8'h7A);
        host.wr(dfc_pkg::ADDR_OP_LOCAL, 8'h6B);
        host.wr(dfc_pkg::ADDR_OP_REMOTE2, 8'h5C);
        temps_i = '{remote1: 8'h11, local_t: 8'h22, remote2: 8'h33};
        event_pulse();
        chk(op_remote1_o, 8'h7A);
        chk(op_local_o, 8'h6B);
        chk(op_remote2_o, 8'h5C);
        rdchk(dfc_pkg::ADDR_OP_REMOTE1, 8'h7A);
        rdchk(dfc_pkg::ADDR_OP_LOCAL, 8'h6B);
        rdchk(dfc_pkg::ADDR_OP_REMOTE2, 8'h5C);
    endtask : t_capture
    task automatic t_guard();
        host.wr(dfc_pkg::ADDR_CTRL1, 8'h02);
        @(negedge clk_i);
        {standby_i, core_below_i, processor_hot_input_i, shutdown_req_i} = 4'h7;
        #1;
        chk({6'h00, core_low_status_o, alert_req_o}, 8'h00);
        @(negedge clk_i);
        standby_i = 1;
        #1;
        chk({6'h00, core_low_status_o, alert_req_o}, 8'h03);
        chk({6'h00, processor_hot_mon_o, dyn_floor_allow_o}, 8'h00);
        chk({7'h00, shutdown_o}, 8'h00);
        @(negedge clk_i);
        core_below_i = 0;
        #1;
        chk({5'h00, processor_hot_mon_o, dyn_floor_allow_o, shutdown_o}, 8'h07);
    endtask : t_guard
    task automatic t_lock();
        @(negedge clk_i);
        lock_i = 1;
        host.wr(dfc_pkg::ADDR_CTRL1, 8'hFF);
        rdchk(dfc_pkg::ADDR_CTRL1, 8'h02);
        host.wr(dfc_pkg::ADDR_CTRL2, 8'hFF);
        rdchk(dfc_pkg::ADDR_CTRL2, 8'h01);
        host.wr(dfc_pkg::ADDR_OP_REMOTE1, 8'hFF);
        chk(op_remote1_o, 8'h7A);
        rdchk(8'h50, 8'h00);
    endtask : t_lock
    task automatic t_midrun_reset();
        @(negedge clk_i);
        rst_i = 1;
        #1;
        chk(op_remote1_o, dfc_pkg::OP_RESET);
        chk({5'h00, remote2_cycle_code_o}, 8'h00);
        repeat (2) @(negedge clk_i);
        {rst_i, lock_i, core_below_i} = 3'b001;
        rdchk(dfc_pkg::ADDR_CTRL1, dfc_pkg::CTRL1_RESET);
        rdchk(dfc_pkg::ADDR_CTRL2, dfc_pkg::CTRL2_RESET);
        chk({6'h00, core_low_status_o, alert_req_o}, 8'h00);
    endtask : t_midrun_reset
    // ==========================================================
    // Verdict
    task automatic report_and_stop();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(negedge clk_i);
        rst_i = 0;
        t_reset_and_cycle();
        t_capture();
        t_guard();
        t_lock();
        t_midrun_reset();
        report_and_stop();
    end
endmodule : tb_dfc_reg1
`default_nettype wire
